/* shared/amx_defines.svh */
// constants for the mix, limiter and mode control word
`ifndef AMX_DEFINES_SVH
`define AMX_DEFINES_SVH
`define AMX_WORD_W      64
`define AMX_CNT_W       7
`define AMX_WORD_BITS   7'h40
`define AMX_ATK_LSB     36
`define AMX_ATK_MSB     39
`define AMX_REL_LSB     40
`define AMX_REL_MSB     43
`define AMX_MIX_LSB     46
`define AMX_MIX_MSB     49
`define AMX_BRIDGE_BIT  50
`define AMX_HTRIM_LSB   51
`define AMX_HTRIM_MSB   55
`define AMX_LTRIM_LSB   56
`define AMX_LTRIM_MSB   60
`define AMX_LOWPWR_BIT  61
`define AMX_SPEED_BIT   62
`define AMX_MOD_BIT     63
`define AMX_ATK_RST     4'h2
`define AMX_REL_RST     4'hA
`define AMX_MIX_RST     4'h9
`define AMX_HTRIM_RST   5'h10
`define AMX_LTRIM_RST   5'h00
`define AMX_LTRIM_MAX   5'h08
`define AMX_HTRIM_MIN   5'h08
`define AMX_HTRIM_MAX   5'h10
`define AMX_ATK_MAXCODE 4'h8
`define AMX_REL_BASE    20'h00010
`define AMX_PER_W       20
`define AMX_ATT_W       8
`define AMX_ATT_MAX     8'hBE
`define AMX_SW          24
`define AMX_SRC_MUTE    2'h0
`define AMX_SRC_RIGHT   2'h1
`define AMX_SRC_LEFT    2'h2
`define AMX_SRC_AVG     2'h3
`define AMX_HALF_CYC    4'h4
`endif

/* shared/amx_pkg.sv */
// types for the two ends of the control link: amplifier mode and host sender state
package amx_pkg;
    typedef enum logic [1:0] {
        AMX_MODE_SCHEME1_SLOW = 2'h0,
        AMX_MODE_SCHEME1_FAST = 2'h1,
        AMX_MODE_SCHEME2      = 2'h2,
        AMX_MODE_RESERVED     = 2'h3
    } amx_mode_t;
    typedef enum logic [1:0] {
        AMX_H_IDLE = 2'h0,
        AMX_H_LOW  = 2'h1,
        AMX_H_HIGH = 2'h3,
        AMX_H_END  = 2'h2
    } amx_hstate_t;
endpackage

/* shared/amx_link_if.sv */
// 3-wire serial control link between host and amplifier
`timescale 1ns/1ps
interface amx_link_if;
    logic sclk;
    logic sdata;
    logic cs_n;
    modport host (output sclk, output sdata, output cs_n);
    modport dev  (input sclk, input sdata, input cs_n);
endinterface

/* hw/amx_device.sv */
// amplifier end: control word receiver, mix matrix, limiter and mode decode
`timescale 1ns/1ps
`include "amx_defines.svh"
// Functional notes
// - attack code sets periods 1 to 16384
// - attack code resets to 0010, 4 periods
// - recovery code bits 40-43, doubling per code
// - recovery 0001=32 up to 1111=524288
// - recovery code resets to 1010, 16384
// - mix code bits 46-49, per channel source
// - upper mix bits pick left output
// - lower mix bits pick right output
// - mix code resets to 1001, straight
// - bit 50 gates output bridge drive
// - bridge drive off after reset
// - host enables bridge once power safe
// - host keeps low trim 00000-01000
// - host keeps high trim 01000-10000
// - bit 61 low power, gates silence
// - bit 62 speed, bit 63 scheme
// - decode speed and scheme to mode
// - host prefers second scheme, low speed
// - attack code bits 36-39, quadrupling
module amx_device (
    input  wire logic                    clk,
    input  wire logic                    nrst,
    amx_link_if.dev                      link,
    input  wire logic signed [`AMX_SW-1:0] in_left,
    input  wire logic signed [`AMX_SW-1:0] in_right,
    input  wire logic                    sample_tick,
    input  wire logic                    clip_detect,
    output logic signed [`AMX_SW-1:0]    out_left,
    output logic signed [`AMX_SW-1:0]    out_right,
    output logic [`AMX_ATT_W-1:0]        limit_atten,
    output logic                         bridge_on,
    output logic                         idle_power_save,
    output logic                         digital_silence,
    output logic                         high_speed,
    output logic                         mod_scheme2,
    output amx_pkg::amx_mode_t           pwm_mode,
    output logic [4:0]                   low_trim,
    output logic [4:0]                   high_trim,
    output logic [3:0]                   source_mix_code
);
    // word clock periods per step for an attack code
    function automatic logic [`AMX_PER_W-1:0] attack_period(input logic [3:0] code);
        logic [3:0] c;
        c = code;
        if (c > `AMX_ATK_MAXCODE)
            c = `AMX_ATK_MAXCODE;
        if (c == 4'h0)
            c = 4'h1;
        attack_period = `AMX_PER_W'(1) << (5'(c - 4'h1) * 5'h2);
    endfunction

    function automatic logic [`AMX_PER_W-1:0] release_period(input logic [3:0] code);
        release_period = `AMX_REL_BASE << code;
    endfunction

    function automatic logic signed [`AMX_SW-1:0] pick_src(
        input logic [1:0] sel,
        input logic signed [`AMX_SW-1:0] l,
        input logic signed [`AMX_SW-1:0] r);
        logic signed [`AMX_SW:0] sum;
        sum = {l[`AMX_SW-1], l} + {r[`AMX_SW-1], r};
        unique case (sel)
            `AMX_SRC_MUTE:  pick_src = '0;
            `AMX_SRC_RIGHT: pick_src = r;
            `AMX_SRC_LEFT:  pick_src = l;
            `AMX_SRC_AVG:   pick_src = sum[`AMX_SW:1];
        endcase
    endfunction

    // serial receiver
    logic [`AMX_WORD_W-1:0] shift_reg, shift_next;
    logic [`AMX_CNT_W-1:0]  cnt_reg, cnt_next;
    logic                   sclk_reg, cs_reg;
    logic [3:0]             atk_reg, atk_next;
    logic [3:0]             rel_reg, rel_next;
    logic [3:0]             mix_reg, mix_next;
    logic                   bridge_reg, bridge_next;
    logic [4:0]             htrim_reg, htrim_next;
    logic [4:0]             ltrim_reg, ltrim_next;
    logic                   lowpwr_reg, lowpwr_next;
    logic                   speed_reg, speed_next;
    logic                   mod_reg, mod_next;

    always_comb begin
        shift_next  = shift_reg;
        cnt_next    = cnt_reg;
        atk_next    = atk_reg;
        rel_next    = rel_reg;
        mix_next    = mix_reg;
        bridge_next = bridge_reg;
        htrim_next  = htrim_reg;
        ltrim_next  = ltrim_reg;
        lowpwr_next = lowpwr_reg;
        speed_next  = speed_reg;
        mod_next    = mod_reg;
        if (!link.cs_n) begin
            // msb first; the first bit past a full word is counted and voids the frame, later bits are dropped
            if (link.sclk && !sclk_reg && cnt_reg <= `AMX_WORD_BITS) begin
                shift_next = {shift_reg[`AMX_WORD_W-2:0], link.sdata};
                cnt_next   = cnt_reg + `AMX_CNT_W'(1);
            end
        end else begin
            cnt_next = '0;
            // a short or long frame leaves every field untouched
            if (!cs_reg && cnt_reg == `AMX_WORD_BITS) begin
                atk_next    = shift_reg[`AMX_ATK_MSB:`AMX_ATK_LSB];
                rel_next    = shift_reg[`AMX_REL_MSB:`AMX_REL_LSB];
                mix_next    = shift_reg[`AMX_MIX_MSB:`AMX_MIX_LSB];
                bridge_next = shift_reg[`AMX_BRIDGE_BIT];
                htrim_next  = shift_reg[`AMX_HTRIM_MSB:`AMX_HTRIM_LSB];
                ltrim_next  = shift_reg[`AMX_LTRIM_MSB:`AMX_LTRIM_LSB];
                lowpwr_next = shift_reg[`AMX_LOWPWR_BIT];
                speed_next  = shift_reg[`AMX_SPEED_BIT];
                mod_next    = shift_reg[`AMX_MOD_BIT];
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shift_reg  <= '0;
            cnt_reg    <= '0;
            sclk_reg   <= 1'b0;
            cs_reg     <= 1'b1;
            atk_reg    <= `AMX_ATK_RST;
            rel_reg    <= `AMX_REL_RST;
            mix_reg    <= `AMX_MIX_RST;
            bridge_reg <= 1'b0;
            htrim_reg  <= `AMX_HTRIM_RST;
            ltrim_reg  <= `AMX_LTRIM_RST;
            lowpwr_reg <= 1'b0;
            speed_reg  <= 1'b0;
            mod_reg    <= 1'b0;
        end else begin
            shift_reg  <= shift_next;
            cnt_reg    <= cnt_next;
            sclk_reg   <= link.sclk;
            cs_reg     <= link.cs_n;
            atk_reg    <= atk_next;
            rel_reg    <= rel_next;
            mix_reg    <= mix_next;
            bridge_reg <= bridge_next;
            htrim_reg  <= htrim_next;
            ltrim_reg  <= ltrim_next;
            lowpwr_reg <= lowpwr_next;
            speed_reg  <= speed_next;
            mod_reg    <= mod_next;
        end
    end

    // limiter: attack while clipping, release otherwise
    logic [`AMX_ATT_W-1:0] att_reg, att_next;
    logic [`AMX_PER_W-1:0] tick_reg, tick_next;
    logic                  dir_reg, dir_next;
    logic [`AMX_PER_W-1:0] period;

    always_comb begin
        att_next  = att_reg;
        tick_next = tick_reg;
        dir_next  = clip_detect;
        period    = clip_detect ? attack_period(atk_reg) : release_period(rel_reg);
        if (dir_reg != clip_detect) begin
            // restart the wait so a direction change never takes a short step
            tick_next = '0;
        end else if (sample_tick) begin
            if (tick_reg >= period - `AMX_PER_W'(1)) begin
                tick_next = '0;
                if (clip_detect && att_reg < `AMX_ATT_MAX)
                    att_next = att_reg + `AMX_ATT_W'(1);
                else if (!clip_detect && att_reg != '0)
                    att_next = att_reg - `AMX_ATT_W'(1);
            end else begin
                tick_next = tick_reg + `AMX_PER_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            att_reg  <= '0;
            tick_reg <= '0;
            dir_reg  <= 1'b0;
        end else begin
            att_reg  <= att_next;
            tick_reg <= tick_next;
            dir_reg  <= dir_next;
        end
    end

    // mix matrix and status outputs
    logic signed [`AMX_SW-1:0] ol_next, or_next;
    logic                      silence_next;
    amx_pkg::amx_mode_t        mode_next;

    always_comb begin
        ol_next = out_left;
        or_next = out_right;
        if (sample_tick) begin
            ol_next = pick_src(mix_reg[3:2], in_left, in_right);
            or_next = pick_src(mix_reg[1:0], in_left, in_right);
        end
        silence_next = lowpwr_reg && in_left == '0 && in_right == '0;
        unique case ({mod_reg, speed_reg})
            2'h0:    mode_next = amx_pkg::AMX_MODE_SCHEME1_SLOW;
            2'h1:    mode_next = amx_pkg::AMX_MODE_SCHEME1_FAST;
            2'h2:    mode_next = amx_pkg::AMX_MODE_SCHEME2;
            2'h3:    mode_next = amx_pkg::AMX_MODE_RESERVED;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_left        <= '0;
            out_right       <= '0;
            digital_silence <= 1'b0;
            pwm_mode        <= amx_pkg::AMX_MODE_SCHEME1_SLOW;
            limit_atten     <= '0;
            bridge_on       <= 1'b0;
            idle_power_save <= 1'b0;
            high_speed      <= 1'b0;
            mod_scheme2     <= 1'b0;
            low_trim        <= `AMX_LTRIM_RST;
            high_trim       <= `AMX_HTRIM_RST;
            source_mix_code <= `AMX_MIX_RST;
        end else begin
            out_left        <= ol_next;
            out_right       <= or_next;
            digital_silence <= silence_next;
            pwm_mode        <= mode_next;
            limit_atten     <= att_reg;
            bridge_on       <= bridge_reg;
            idle_power_save <= lowpwr_reg;
            high_speed      <= speed_reg;
            mod_scheme2     <= mod_reg;
            low_trim        <= ltrim_reg;
            high_trim       <= htrim_reg;
            source_mix_code <= mix_reg;
        end
    end
endmodule // amx_device

/* hw/amx_host.sv */
// host end: sends one 64-bit control word per request, keeping safe values
`timescale 1ns/1ps
`include "amx_defines.svh"
module amx_host (
    input  wire logic                   clk,
    input  wire logic                   nrst,
    amx_link_if.host                    link,
    input  wire logic                   send,
    input  wire logic [`AMX_WORD_W-1:0] word_in,
    input  wire logic                   power_good,
    output logic                        busy
);
    amx_pkg::amx_hstate_t   st_reg, st_next;
    logic [`AMX_WORD_W-1:0] sh_reg, sh_next;
    logic [`AMX_CNT_W-1:0]  cnt_reg, cnt_next;
    logic [3:0]             div_reg, div_next;
    logic                   sclk_next, sdata_next, cs_next, busy_next;
    logic [`AMX_WORD_W-1:0] w;

    always_comb begin
        w = word_in;
        // bridge held off until power is reported safe
        w[`AMX_BRIDGE_BIT] = word_in[`AMX_BRIDGE_BIT] & power_good;
        if (word_in[`AMX_LTRIM_MSB:`AMX_LTRIM_LSB] > `AMX_LTRIM_MAX)
            w[`AMX_LTRIM_MSB:`AMX_LTRIM_LSB] = `AMX_LTRIM_RST;
        if (word_in[`AMX_HTRIM_MSB:`AMX_HTRIM_LSB] < `AMX_HTRIM_MIN ||
            word_in[`AMX_HTRIM_MSB:`AMX_HTRIM_LSB] > `AMX_HTRIM_MAX)
            w[`AMX_HTRIM_MSB:`AMX_HTRIM_LSB] = `AMX_HTRIM_RST;
        // the undefined combination falls back to the preferred mode
        if (word_in[`AMX_MOD_BIT])
            w[`AMX_SPEED_BIT] = 1'b0;
    end

    always_comb begin
        st_next    = st_reg;
        sh_next    = sh_reg;
        cnt_next   = cnt_reg;
        div_next   = div_reg;
        sclk_next  = link.sclk;
        sdata_next = link.sdata;
        cs_next    = link.cs_n;
        busy_next  = busy;
        unique case (st_reg)
            amx_pkg::AMX_H_IDLE: begin
                if (send) begin
                    sh_next    = {w[`AMX_WORD_W-2:0], 1'b0};
                    sdata_next = w[`AMX_WORD_W-1];
                    cs_next    = 1'b0;
                    busy_next  = 1'b1;
                    cnt_next   = '0;
                    div_next   = '0;
                    st_next    = amx_pkg::AMX_H_LOW;
                end
            end
            amx_pkg::AMX_H_LOW: begin
                div_next = div_reg + 4'h1;
                if (div_reg == `AMX_HALF_CYC - 4'h1) begin
                    div_next  = '0;
                    sclk_next = 1'b1;
                    cnt_next  = cnt_reg + `AMX_CNT_W'(1);
                    st_next   = amx_pkg::AMX_H_HIGH;
                end
            end
            amx_pkg::AMX_H_HIGH: begin
                div_next = div_reg + 4'h1;
                if (div_reg == `AMX_HALF_CYC - 4'h1) begin
                    div_next  = '0;
                    sclk_next = 1'b0;
                    if (cnt_reg == `AMX_WORD_BITS) begin
                        st_next = amx_pkg::AMX_H_END;
                    end else begin
                        sdata_next = sh_reg[`AMX_WORD_W-1];
                        sh_next    = {sh_reg[`AMX_WORD_W-2:0], 1'b0};
                        st_next    = amx_pkg::AMX_H_LOW;
                    end
                end
            end
            amx_pkg::AMX_H_END: begin
                div_next = div_reg + 4'h1;
                if (div_reg == `AMX_HALF_CYC - 4'h1) begin
                    cs_next    = 1'b1;
                    sdata_next = 1'b0;
                    busy_next  = 1'b0;
                    st_next    = amx_pkg::AMX_H_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg     <= amx_pkg::AMX_H_IDLE;
            sh_reg     <= '0;
            cnt_reg    <= '0;
            div_reg    <= '0;
            link.sclk  <= 1'b0;
            link.sdata <= 1'b0;
            link.cs_n  <= 1'b1;
            busy       <= 1'b0;
        end else begin
            st_reg     <= st_next;
            sh_reg     <= sh_next;
            cnt_reg    <= cnt_next;
            div_reg    <= div_next;
            link.sclk  <= sclk_next;
            link.sdata <= sdata_next;
            link.cs_n  <= cs_next;
            busy       <= busy_next;
        end
    end
endmodule // amx_host

/* verification/amx_link_props.sv */
// wire-level checks on the serial control link between the two ends
`timescale 1ns/1ps
module amx_link_props (
    input logic clk,
    input logic nrst,
    input logic sclk,
    input logic sdata,
    input logic cs_n
);
    localparam int FR_MIN = 510;
    localparam int FR_MAX = 520;
    logic        sclk_d_reg;
    logic        sclk_d_next;
    logic [6:0]  bits_reg;
    logic [6:0]  bits_next;
    logic [63:0] word_reg;
    logic [63:0] word_next;
    logic        rise;
    assign rise = sclk && !sclk_d_reg && !cs_n;
    // count and word survive the first idle cycle so the frame end can inspect them
    always_comb begin
        sclk_d_next = sclk;
        bits_next   = cs_n ? 7'h00 : bits_reg + {6'h00, rise};
        word_next   = (rise) ? {word_reg[62:0], sdata} : word_reg;
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sclk_d_reg <= 1'b0;
            bits_reg   <= 7'h00;
            word_reg   <= 64'h0000000000000000;
        end else begin
            sclk_d_reg <= sclk_d_next;
            bits_reg   <= bits_next;
            word_reg   <= word_next;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    idle_clock_low_a: assert property (cs_n |-> !sclk)
        else $error("serial clock high outside a frame");
    data_hold_a: assert property (sclk && $past(sclk) |-> $stable(sdata))
        else $error("data moved while serial clock high");
    high_phase_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("serial clock high phase not four cycles");
    low_phase_a: assert property ($fell(sclk) |-> !sclk [*4])
        else $error("serial clock low phase too short");
    frame_lead_a: assert property ($fell(cs_n) |-> !sclk [*4] ##1 sclk)
        else $error("first clock edge not four cycles after select");
    frame_len_a: assert property ($fell(cs_n) |-> ##[FR_MIN:FR_MAX] $rose(cs_n))
        else $error("frame length out of range");
    bit_count_a: assert property ($rose(cs_n) |-> bits_reg == 7'h40)
        else $error("frame did not carry 64 bits");
    scheme_speed_a: assert property ($rose(cs_n) && word_reg[63] |-> !word_reg[62])
        else $error("high speed sent with second scheme");
    low_trim_a: assert property ($rose(cs_n) |-> word_reg[60:56] <= 5'h08)
        else $error("low side trim above range");
    high_trim_a: assert property ($rose(cs_n) |->
        word_reg[55:51] >= 5'h08 && word_reg[55:51] <= 5'h10)
        else $error("high side trim out of range");
    // first edge skipped: the reset may only reach the host flops at that edge
    reset_idle_a: assert property (disable iff (1'b0) !nrst && $past(!nrst) |-> cs_n && !sclk)
        else $error("link not idle in reset");
    frame_end_c: cover property ($rose(cs_n));
    scheme2_c: cover property ($rose(cs_n) && word_reg[63]);
    bridge_c: cover property ($rose(cs_n) && word_reg[50]);
endmodule // amx_link_props

/* verification/audio_mix_limiter_mode_control_tb.sv */
// self-checking bench joining the host and amplifier ends
`timescale 1ns/1ps
`include "amx_defines.svh"
module audio_mix_limiter_mode_control_tb;
    logic                     clk;
    logic                     nrst;
    logic                     send;
    logic                     power_good;
    logic                     busy;
    logic                     sample_tick;
    logic                     clip_detect;
    logic [63:0]              word_in;
    logic signed [`AMX_SW-1:0] in_left;
    logic signed [`AMX_SW-1:0] in_right;
    logic signed [`AMX_SW-1:0] out_left;
    logic signed [`AMX_SW-1:0] out_right;
    logic [7:0]               limit_atten;
    logic                     bridge_on;
    logic                     idle_power_save;
    logic                     digital_silence;
    logic                     high_speed;
    logic                     mod_scheme2;
    amx_pkg::amx_mode_t       pwm_mode;
    logic [4:0]               low_trim;
    logic [4:0]               high_trim;
    logic [3:0]               source_mix_code;
    logic [7:0]               att_e;
    int                       n_fail;
    int                       check_count;
    amx_link_if link ();
    amx_host i_amx_host (.clk(clk), .nrst(nrst), .link(link), .send(send),
        .word_in(word_in), .power_good(power_good), .busy(busy));
    amx_device i_amx_device (.clk(clk), .nrst(nrst), .link(link), .in_left(in_left),
        .in_right(in_right), .sample_tick(sample_tick), .clip_detect(clip_detect),
        .out_left(out_left), .out_right(out_right), .limit_atten(limit_atten),
        .bridge_on(bridge_on), .idle_power_save(idle_power_save),
        .digital_silence(digital_silence), .high_speed(high_speed),
        .mod_scheme2(mod_scheme2), .pwm_mode(pwm_mode), .low_trim(low_trim),
        .high_trim(high_trim), .source_mix_code(source_mix_code));
    amx_link_props i_amx_link_props (.clk(clk), .nrst(nrst), .sclk(link.sclk),
        .sdata(link.sdata), .cs_n(link.cs_n));
    always #12.5 clk = ~clk;
    task automatic print_verdict();
        if (n_fail == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic tick();
        @(negedge clk) sample_tick = 1'b1;
        @(negedge clk) sample_tick = 1'b0;
    endtask
    // flags: mod, speed, low power, bridge
    function automatic logic [63:0] mk(input logic [3:0] atk, input logic [3:0] rel,
        input logic [3:0] mix, input logic [4:0] ht, input logic [4:0] lt,
        input logic [3:0] f);
        logic [63:0] w;
        w = 64'h0000000000000000;
        w[39:36] = atk;
        w[43:40] = rel;
        w[49:46] = mix;
        w[50] = f[0];
        w[55:51] = ht;
        w[60:56] = lt;
        w[61] = f[1];
        w[63:62] = f[3:2];
        return w;
    endfunction
    function automatic logic signed [`AMX_SW-1:0] sel_exp(input logic [1:0] s);
        logic signed [`AMX_SW:0] sum;
        sum = {in_left[`AMX_SW-1], in_left} + {in_right[`AMX_SW-1], in_right};
        case (s)
            2'h0: return 24'h000000;
            2'h1: return in_right;
            2'h2: return in_left;
            default: return sum[`AMX_SW:1];
        endcase
    endfunction
    task automatic send_w(input logic [63:0] w, input logic pg);
        @(negedge clk);
        power_good = pg;
        word_in = w;
        send = 1'b1;
        @(negedge clk) send = 1'b0;
        for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(negedge clk);
        // a frame that never ends is a mismatch, not a silent fall-through
        chk(busy, 1'b0);
        wt(4);
    endtask
    // step period p: no change after p-1 ticks, one step on tick p
    task automatic lim(input int p, input logic up);
        for (int i = 1; i < p; i++) tick();
        wt(2);
        chk(limit_atten, att_e);
        tick();
        wt(2);
        att_e = up ? att_e + 8'h01 : att_e - 8'h01;
        chk(limit_atten, att_e);
    endtask
    initial begin
        #2000000;
        n_fail++;
        print_verdict();
    end
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        send = 1'b0;
        word_in = 64'h0000000000000000;
        power_good = 1'b0;
        sample_tick = 1'b0;
        clip_detect = 1'b0;
        in_left = 24'h000000;
        in_right = 24'h000000;
        n_fail = 0;
        check_count = 0;
        att_e = 8'h00;
        wt(3);
        nrst = 1'b1;
        wt(1);
        chk(source_mix_code, 4'h9);
        chk(bridge_on, 1'b0);
        chk(low_trim, 5'h00);
        chk(high_trim, 5'h10);
        chk(idle_power_save, 1'b0);
        chk(pwm_mode, amx_pkg::AMX_MODE_SCHEME1_SLOW);
        clip_detect = 1'b1;
        lim(4, 1'b1);
        lim(4, 1'b1);
        clip_detect = 1'b0;
        lim(16384, 1'b0);
        send_w(mk(4'h1, 4'h2, 4'h9, 5'h10, 5'h00, 4'h0), 1'b1);
        clip_detect = 1'b1;
        lim(1, 1'b1);
        send_w(mk(4'h3, 4'h2, 4'h9, 5'h10, 5'h00, 4'h0), 1'b1);
        clip_detect = 1'b0;
        wt(1);
        clip_detect = 1'b1;
        lim(16, 1'b1);
        clip_detect = 1'b0;
        lim(64, 1'b0);
        send_w(mk(4'h3, 4'h1, 4'h9, 5'h10, 5'h00, 4'h0), 1'b1);
        clip_detect = 1'b1;
        wt(1);
        clip_detect = 1'b0;
        lim(32, 1'b0);
        for (int c = 0; c < 16; c++) begin
            in_left = 24'hFFFFEF;
            in_right = 24'h000004;
            send_w(mk(4'h2, 4'hA, c[3:0], 5'(c + 4), c[4:0], {c[1], c[0], c[2], c[3]}), c[2]);
            tick();
            wt(2);
            chk(source_mix_code, c[3:0]);
            chk(out_left, sel_exp(c[3:2]));
            chk(out_right, sel_exp(c[1:0]));
            chk(bridge_on, c[3] & c[2]);
            chk(low_trim, (c > 8) ? 5'h00 : c[4:0]);
            chk(high_trim, (c + 4 >= 8 && c + 4 <= 16) ? 5'(c + 4) : 5'h10);
            chk(idle_power_save, c[2]);
            chk(mod_scheme2, c[1]);
            chk(high_speed, c[0] & ~c[1]);
            chk(pwm_mode, c[1] ? amx_pkg::AMX_MODE_SCHEME2 : (c[0] ?
                amx_pkg::AMX_MODE_SCHEME1_FAST : amx_pkg::AMX_MODE_SCHEME1_SLOW));
            in_left = 24'h000000;
            in_right = 24'h000000;
            wt(3);
            chk(digital_silence, c[2]);
        end
        print_verdict();
    end
endmodule // audio_mix_limiter_mode_control_tb
